// File: lcdx_exec.sv
// lcd instruction executor behind an axi4-lite slave
// assumes one clock aclk at 250 mhz and a synchronous active-low reset
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "lcdx_defs.svh"
module lcdx_exec
#(
   parameter int EXEC_SHORT = `LCDX_SHORT_CYC,
   parameter int EXEC_LONG = `LCDX_LONG_CYC,
   parameter int DISP_DEPTH = 128
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address channel
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address channel
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam int CW = $clog2(EXEC_LONG + 1);
   localparam int DW = $clog2(DISP_DEPTH);

   logic aw_full_r;
   logic aw_full_nxt;
   logic w_full_r;
   logic w_full_nxt;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic w_lane_r;
   logic wr_go;
   logic ar_go;
   logic busy;
   logic instr_act;
   logic dwr_act;
   logic rd_act;
   logic start;
   logic [CW-1:0] load;
   lcdx_pkg::lcdx_kind_e kind;
   lcdx_pkg::lcdx_state_e st_r;
   logic [CW-1:0] cnt_r;
   logic [DW-1:0] clr_idx_r;
   logic [6:0] ac_r;
   logic sel_glyph_r;
   lcdx_pkg::lcdx_entry_s entry_r;
   lcdx_pkg::lcdx_dctl_s dctl_r;
   logic [5:0] shift_r;
   logic font11_r;
   lcdx_pkg::lcdx_xfer_s instruction_latch_r;
   lcdx_pkg::lcdx_xfer_s data_latch_r;
   logic [7:0] probe_code_r;
   logic [3:0] probe_row_r;
   logic [5:0] glyph_addr;
   logic glyph_hit;
   logic [7:0] display_ram [DISP_DEPTH];
   logic [7:0] glyph_ram [64];

   // instruction byte to operation
   function automatic lcdx_pkg::lcdx_kind_e decode(input logic [7:0] c);
      if (c[7])
         decode = lcdx_pkg::K_DADDR;
      else if (c[6])
         decode = lcdx_pkg::K_GADDR;
      else if (c[5] || c[4])
         decode = lcdx_pkg::K_OTHER;
      else if (c[3])
         decode = lcdx_pkg::K_DCTL;
      else if (c[2])
         decode = lcdx_pkg::K_ENTRY;
      else if (c[1])
         decode = lcdx_pkg::K_HOME;
      else if (c[0])
         decode = lcdx_pkg::K_CLEAR;
      else
         decode = lcdx_pkg::K_NONE;
   endfunction

   // address counter step, glyph space wraps in six bits
   function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up,
                                          input logic g);
      logic [6:0] n;
      n = up ? a + 7'h01 : a - 7'h01;
      ac_step = g ? {1'b0, n[5:0]} : n;
   endfunction

   // display shift offset step over one 40-digit line
   function automatic logic [5:0] off_step(input logic [5:0] o, input logic left);
      if (left)
         off_step = (o == `LCDX_SHIFT_LAST) ? 6'h00 : o + 6'h01;
      else
         off_step = (o == 6'h00) ? `LCDX_SHIFT_LAST : o - 6'h01;
   endfunction

   // mapped offsets
   function automatic logic addr_ok(input logic [7:0] a);
      if (a == `LCDX_OFF_INSTR || a == `LCDX_OFF_DATA || a == `LCDX_OFF_STATE)
         addr_ok = 1'b1;
      else if (a == `LCDX_OFF_CFG || a == `LCDX_OFF_GLYPH)
         addr_ok = 1'b1;
      else
         addr_ok = 1'b0;
   endfunction

   // request decode; writes win over a data read in the same cycle
   assign wr_go = aw_full_r & w_full_r & ~s_axi_bvalid;
   assign ar_go = s_axi_arvalid & s_axi_arready;
   assign busy = (st_r != lcdx_pkg::ST_IDLE);
   assign kind = decode(w_data_r[7:0]);
   assign instr_act = wr_go & w_lane_r & (aw_addr_r == `LCDX_OFF_INSTR) & ~busy;
   assign dwr_act = wr_go & w_lane_r & (aw_addr_r == `LCDX_OFF_DATA) & ~busy;
   assign rd_act = ar_go & (s_axi_araddr == `LCDX_OFF_DATA) & ~busy & ~instr_act & ~dwr_act;
   assign start = instr_act | dwr_act | rd_act;
   assign aw_full_nxt = wr_go ? 1'b0 : (aw_full_r | (s_axi_awvalid & s_axi_awready));
   assign w_full_nxt = wr_go ? 1'b0 : (w_full_r | (s_axi_wvalid & s_axi_wready));
   assign load = (instr_act && (kind == lcdx_pkg::K_CLEAR || kind == lcdx_pkg::K_HOME)) ?
                 CW'(EXEC_LONG - 1) : CW'(EXEC_SHORT - 1);

   // write address and data holding, either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_lane_r <= 1'b0;
      end
      else
      begin
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         s_axi_awready <= ~aw_full_nxt;
         s_axi_wready <= ~w_full_nxt;
         if (s_axi_awvalid && s_axi_awready)
            aw_addr_r <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data_r <= s_axi_wdata;
            w_lane_r <= s_axi_wstrb[0];
         end
      end
   end

   // write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `LCDX_RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_ok(aw_addr_r) ? `LCDX_RESP_OKAY : `LCDX_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // read channel; status word carries busy and address counter
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `LCDX_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~(ar_go | (s_axi_rvalid & ~s_axi_rready));
         if (ar_go)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `LCDX_RESP_OKAY;
            if (s_axi_araddr == `LCDX_OFF_INSTR)
               s_axi_rdata <= {24'h00_0000, busy, ac_r};
            else if (s_axi_araddr == `LCDX_OFF_DATA)
               s_axi_rdata <= {24'h00_0000, sel_glyph_r ? glyph_ram[ac_r[5:0]] :
                               display_ram[ac_r[DW-1:0]]};
            else if (s_axi_araddr == `LCDX_OFF_STATE)
               s_axi_rdata <= {data_latch_r.code, instruction_latch_r.code, 2'b00, shift_r,
                               busy, font11_r, sel_glyph_r, dctl_r.blink, dctl_r.cur,
                               dctl_r.disp, entry_r.shen, entry_r.inc};
            else if (s_axi_araddr == `LCDX_OFF_CFG)
               s_axi_rdata <= {31'h0000_0000, font11_r};
            else if (s_axi_araddr == `LCDX_OFF_GLYPH)
               s_axi_rdata <= {25'h000_0000, glyph_hit, glyph_addr};
            else
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `LCDX_RESP_SLVERR;
            end
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // execution timer and clear walk
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= lcdx_pkg::ST_IDLE;
         cnt_r <= '0;
         clr_idx_r <= '0;
      end
      else
      begin
         case (st_r)
            lcdx_pkg::ST_IDLE:
            begin
               if (start)
               begin
                  cnt_r <= load;
                  clr_idx_r <= '0;
                  if (instr_act && kind == lcdx_pkg::K_CLEAR)
                     st_r <= lcdx_pkg::ST_CLEAR;
                  else
                     st_r <= lcdx_pkg::ST_EXEC;
               end
            end
            lcdx_pkg::ST_CLEAR:
            begin
               clr_idx_r <= clr_idx_r + 1'b1;
               if (cnt_r != '0)
                  cnt_r <= cnt_r - 1'b1;
               if (clr_idx_r == DW'(DISP_DEPTH - 1))
                  st_r <= lcdx_pkg::ST_EXEC;
            end
            lcdx_pkg::ST_EXEC:
            begin
               if (cnt_r == '0)
                  st_r <= lcdx_pkg::ST_IDLE;
               else
                  cnt_r <= cnt_r - 1'b1;
            end
            default:
               st_r <= lcdx_pkg::ST_IDLE;
         endcase
      end
   end

   // display ram: clear walk fills spaces, else host writes
   always_ff @(posedge aclk)
   begin
      if (st_r == lcdx_pkg::ST_CLEAR)
         display_ram[clr_idx_r] <= `LCDX_SPACE_CODE;
      else if (dwr_act && !sel_glyph_r)
         display_ram[ac_r[DW-1:0]] <= w_data_r[7:0];
   end

   // glyph ram host writes
   always_ff @(posedge aclk)
   begin
      if (dwr_act && sel_glyph_r)
         glyph_ram[ac_r[5:0]] <= w_data_r[7:0];
   end

   // address counter and ram select
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ac_r <= `LCDX_HOME_ADDR;
         sel_glyph_r <= 1'b0;
      end
      else if (instr_act)
      begin
         case (kind)
            lcdx_pkg::K_CLEAR, lcdx_pkg::K_HOME:
            begin
               ac_r <= `LCDX_HOME_ADDR;
               sel_glyph_r <= 1'b0;
            end
            lcdx_pkg::K_GADDR:
            begin
               ac_r <= {1'b0, w_data_r[5:0]};
               sel_glyph_r <= 1'b1;
            end
            lcdx_pkg::K_DADDR:
            begin
               ac_r <= w_data_r[6:0];
               sel_glyph_r <= 1'b0;
            end
            default:
               ac_r <= ac_r;
         endcase
      end
      else if (dwr_act || rd_act)
         ac_r <= ac_step(ac_r, entry_r.inc, sel_glyph_r);
   end

   // entry mode and display control
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         entry_r <= `LCDX_ENTRY_RST;
         dctl_r <= `LCDX_DCTL_RST;
      end
      else if (instr_act && kind == lcdx_pkg::K_CLEAR)
         entry_r.inc <= 1'b1;
      else if (instr_act && kind == lcdx_pkg::K_ENTRY)
         entry_r <= w_data_r[1:0];
      else if (instr_act && kind == lcdx_pkg::K_DCTL)
         dctl_r <= w_data_r[2:0];
   end

   // whole-display shift offset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         shift_r <= 6'h00;
      else if (instr_act && (kind == lcdx_pkg::K_CLEAR || kind == lcdx_pkg::K_HOME))
         shift_r <= 6'h00;
      else if (dwr_act && !sel_glyph_r && entry_r.shen)
         shift_r <= off_step(shift_r, entry_r.inc);
   end

   // transfer latches, configuration and glyph probe
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         instruction_latch_r <= '0;
         data_latch_r <= '0;
         font11_r <= 1'b0;
         probe_code_r <= 8'h00;
         probe_row_r <= 4'h0;
      end
      else
      begin
         if (instr_act)
            instruction_latch_r <= '{rs: 1'b0, code: w_data_r[7:0]};
         if (dwr_act)
            data_latch_r <= '{rs: 1'b1, code: w_data_r[7:0]};
         if (wr_go && w_lane_r && aw_addr_r == `LCDX_OFF_CFG)
            font11_r <= w_data_r[`LCDX_CFG_FONT_BIT];
         if (wr_go && w_lane_r && aw_addr_r == `LCDX_OFF_GLYPH)
         begin
            probe_code_r <= w_data_r[7:0];
            probe_row_r <= w_data_r[`LCDX_PROBE_ROW_LSB+:4];
         end
      end
   end

   // glyph address mapping
   lcdx_glyph_map u_glyph_map
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .code(probe_code_r),
      .row(probe_row_r),
      .font11(font11_r),
      .addr_r(glyph_addr),
      .hit_r(glyph_hit)
   );

   // busy length bookkeeping for checks
   int busy_len_r;
   int load_r;
   logic was_clear_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         busy_len_r <= 0;
         load_r <= 0;
         was_clear_r <= 1'b0;
      end
      else if (start)
      begin
         busy_len_r <= 1;
         load_r <= int'(load) + 1;
         was_clear_r <= instr_act && kind == lcdx_pkg::K_CLEAR;
      end
      else if (busy)
         busy_len_r <= busy_len_r + 1;
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   busy_rise_a: assert property (start |=> busy)
      else $error("busy did not rise on accept");
   busy_len_a: assert property ($fell(busy) && !was_clear_r |-> busy_len_r == load_r + 1)
      else $error("execution time wrong");
   clear_len_a: assert property ($fell(busy) && was_clear_r |-> busy_len_r > DISP_DEPTH)
      else $error("clear ended before ram filled");
   status_word_a: assert property (ar_go && s_axi_araddr == `LCDX_OFF_INSTR
      |=> s_axi_rdata[`LCDX_BUSY_BIT] == $past(busy) && s_axi_rdata[6:0] == $past(ac_r))
      else $error("status word wrong");
   latch_instr_a: assert property (instr_act |=> instruction_latch_r.code == $past(w_data_r[7:0]))
      else $error("instruction not latched");
   clear_state_a: assert property (instr_act && kind == lcdx_pkg::K_CLEAR
      |=> ac_r == `LCDX_HOME_ADDR && st_r == lcdx_pkg::ST_CLEAR ##1 clr_idx_r == DW'(1))
      else $error("clear start wrong");
   clear_mode_a: assert property (instr_act && kind == lcdx_pkg::K_CLEAR
      |=> entry_r.inc && shift_r == 6'h00)
      else $error("clear did not reset mode");
   home_state_a: assert property (instr_act && kind == lcdx_pkg::K_HOME
      |=> ac_r == `LCDX_HOME_ADDR && shift_r == 6'h00 && st_r == lcdx_pkg::ST_EXEC)
      else $error("return home wrong");
   entry_store_a: assert property (instr_act && kind == lcdx_pkg::K_ENTRY
      |=> entry_r == $past(w_data_r[1:0]))
      else $error("entry mode not stored");
   dctl_store_a: assert property (instr_act && kind == lcdx_pkg::K_DCTL
      |=> dctl_r == $past(w_data_r[2:0]))
      else $error("display control not stored");
   ac_step_a: assert property (dwr_act || rd_act
      |=> ac_r == ac_step($past(ac_r), $past(entry_r.inc), $past(sel_glyph_r)))
      else $error("address counter step wrong");
   no_shift_a: assert property (rd_act || (dwr_act && (sel_glyph_r || !entry_r.shen))
      |=> $stable(shift_r))
      else $error("display shifted when it must not");
   do_shift_a: assert property (dwr_act && !sel_glyph_r && entry_r.shen
      |=> shift_r == off_step($past(shift_r), $past(entry_r.inc)))
      else $error("display shift wrong");

   clear_done_c: cover property (was_clear_r && $fell(busy));
   shift_left_c: cover property (dwr_act && entry_r.shen && entry_r.inc);
   busy_read_c: cover property (ar_go && s_axi_araddr == `LCDX_OFF_INSTR && busy);
   glyph_write_c: cover property (dwr_act && sel_glyph_r);

endmodule
`default_nettype wire

// File: lcdx_defs.svh
// constants of the lcd instruction executor: offsets, fields, resets, timing
// assumes inclusion by bare name from the executor and the bench
`ifndef LCDX_DEFS_SVH
`define LCDX_DEFS_SVH

// register byte offsets on the axi4-lite slave
`define LCDX_OFF_INSTR 8'h00
`define LCDX_OFF_DATA 8'h04
`define LCDX_OFF_STATE 8'h08
`define LCDX_OFF_CFG 8'h0c
`define LCDX_OFF_GLYPH 8'h10

// axi response codes
`define LCDX_RESP_OKAY 2'b00
`define LCDX_RESP_SLVERR 2'b10

// field positions
`define LCDX_CFG_FONT_BIT 0
`define LCDX_BUSY_BIT 7
`define LCDX_PROBE_ROW_LSB 8

// reset and fill values
`define LCDX_SPACE_CODE 8'h20
`define LCDX_HOME_ADDR 7'h00
`define LCDX_SHIFT_LAST 6'h27
`define LCDX_ENTRY_RST 2'b10
`define LCDX_DCTL_RST 3'b000

// timing: times in their own units, cycle counts derived at 250 mhz
`define LCDX_CLK_MHZ 250
`define LCDX_T_SHORT_US 39
`define LCDX_T_LONG_US 1530
`define LCDX_SHORT_CYC (`LCDX_T_SHORT_US * `LCDX_CLK_MHZ)
`define LCDX_LONG_CYC (`LCDX_T_LONG_US * `LCDX_CLK_MHZ)

`endif

// File: lcdx_pkg.sv
// types shared by the lcd instruction executor files
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package lcdx_pkg;

   // one host transfer: register select level and bus byte
   typedef struct packed
   {
      logic rs;
      logic [7:0] code;
   } lcdx_xfer_s;

   // entry mode bits: increment select and shift enable
   typedef struct packed
   {
      logic inc;
      logic shen;
   } lcdx_entry_s;

   // display control bits
   typedef struct packed
   {
      logic disp;
      logic cur;
      logic blink;
   } lcdx_dctl_s;

   // decoded instruction kind
   typedef enum logic [3:0]
   {
      K_NONE,
      K_CLEAR,
      K_HOME,
      K_ENTRY,
      K_DCTL,
      K_OTHER,
      K_GADDR,
      K_DADDR
   } lcdx_kind_e;

   // execution state
   typedef enum logic [1:0]
   {
      ST_IDLE,
      ST_CLEAR,
      ST_EXEC
   } lcdx_state_e;

endpackage
`default_nettype wire

// File: lcdx_glyph_map.sv
// glyph ram address mapping from character code and glyph row
// assumes code, row and font select are stable logic on aclk
`timescale 1ns/1ps
`default_nettype none
module lcdx_glyph_map
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // lookup request
   input wire logic [7:0] code,
   input wire logic [3:0] row,
   input wire logic font11,
   // mapped address
   output logic [5:0] addr_r,
   output logic hit_r
);

   // user glyphs live where the upper code nibble is zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         addr_r <= 6'h00;
         hit_r <= 1'b0;
      end
      else
      begin
         hit_r <= (code[7:4] == 4'h0);
         if (font11)
            addr_r <= {code[2:1], row};
         else
            addr_r <= {code[2:0], row[2:0]};
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // tall font drops code bits 3 and 0
   glyph_tall_a: assert property (font11 |=> addr_r == {$past(code[2:1]), $past(row)})
      else $error("tall font glyph address wrong");
   glyph_cov_c: cover property (font11 && code[7:4] == 4'h0 ##1 hit_r);

endmodule
`default_nettype wire

// File: lcdx_host.sv
// host-side model: an axi4-lite master issuing one write or one read at a time
// assumes a single aclk; callers sequence the tasks, address and data lines invert once taken
`timescale 1ns/1ps
`default_nettype none
module lcdx_host
(
   // clock
   input wire logic aclk,
   // write address and data
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   // write response
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read address and data
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // idle levels at time zero
   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
   end

   // write: each channel held until taken, then its payload inverted
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awaddr <= ~a;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wdata <= ~d;
         s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
         s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
         done = s_axi_bvalid;
         resp = s_axi_bresp;
         s_axi_bready <= !s_axi_bvalid;
      end
   endtask

   // read: address held until taken, data taken at the rvalid edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_araddr <= ~a;
         s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
         done = s_axi_rvalid;
         d = s_axi_rdata;
         resp = s_axi_rresp;
         s_axi_rready <= !s_axi_rvalid;
      end
   endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench of the lcd instruction executor
// assumes lcdx_exec, lcdx_host and the defines header are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "lcdx_defs.svh"
module tb_top;
   localparam logic [7:0] ains = `LCDX_OFF_INSTR;
   localparam logic [7:0] adat = `LCDX_OFF_DATA;
   localparam logic [7:0] asta = `LCDX_OFF_STATE;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [6:0] ac;
   logic inc, shen, gsel;
   int sh, err_total, check_count;
   logic [7:0] mem [128];

   // short execution counts keep the run brief
   lcdx_exec #(.EXEC_SHORT(20), .EXEC_LONG(200), .DISP_DEPTH(128)) i_lcdx_exec
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   // host model on the bus
   lcdx_host i_lcdx_host
   (
      .aclk(aclk),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   // 250 mhz clock
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // next address counter value, wrapping in six bits for glyph ram
   function automatic logic [6:0] step(input logic [6:0] a, input logic up, input logic g);
      logic [6:0] n;
      n = up ? a + 7'h1 : a - 7'h1;
      return g ? {1'b0, n[5:0]} : n;
   endfunction

   // next shift offset, wrapping within 0..39
   function automatic int shift_nxt(input int s, input logic up);
      return up ? (s + 1) % 40 : (s + 39) % 40;
   endfunction

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // register access with an okay response expected
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      i_lcdx_host.rd(a, d, r);
      chk({30'h0, r}, 32'h0, "read resp");
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      i_lcdx_host.wr(a, d, r);
      chk({30'h0, r}, 32'h0, "write resp");
   endtask

   // poll status until idle, then leave a margin before the next instruction
   task automatic wait_idle();
      logic [31:0] s;
      int n;
      n = 0;
      s = 32'h80;
      while (s[7] !== 1'b0 && n < 400)
      begin
         reg_rd(ains, s);
         n++;
      end
      chk({31'h0, s[7]}, 32'h0, "busy never fell");
      @(posedge aclk);
   endtask

   // busy seen right after accept, then wait
   task automatic post();
      logic [31:0] s;
      reg_rd(ains, s);
      chk({31'h0, s[7]}, 32'h1, "busy after accept");
      wait_idle();
   endtask
   task automatic cmd(input logic [7:0] a, input logic [7:0] c);
      reg_wr(a, {24'h0, c});
      post();
   endtask

   // compare address counter, shift, ram select and entry bits
   task automatic check_model();
      logic [31:0] s;
      reg_rd(ains, s);
      chk({25'h0, s[6:0]}, {25'h0, ac}, "address counter");
      reg_rd(asta, s);
      chk({23'h0, s[13:8], s[5], s[1:0]}, {23'h0, sh[5:0], gsel, shen, inc}, "mode");
   endtask

   // verdict
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // hang guard
   initial
   begin
      #200000;
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end

   // main sequence
   initial
   begin
      logic [31:0] s;
      logic [31:0] r;
      logic [1:0] resp;
      aresetn = 1'b0;
      {err_total, check_count, sh} = '0;
      {ac, shen, gsel, inc} = 10'h1;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      void'($urandom(35));
      check_model();
      i_lcdx_host.rd(8'h20, s, resp);
      chk({s[29:0], resp}, {30'h0, `LCDX_RESP_SLVERR}, "unmapped read");
      i_lcdx_host.wr(8'h20, 32'h1, resp);
      chk({30'h0, resp}, {30'h0, `LCDX_RESP_SLVERR}, "unmapped write");
      $display("test reset done");
      // every entry mode and display control code
      for (int i = 0; i < 12; i++)
      begin
         r = (i < 4) ? 32'h4 | i : 32'h8 | (i - 4);
         cmd(ains, r[7:0]);
         reg_rd(asta, s);
         chk({24'h0, s[23:16]}, r, "instruction latch");
         if (i < 4)
            chk({30'h0, s[1:0]}, {30'h0, r[0], r[1]}, "entry bits");
         else
            chk({29'h0, s[4:2]}, {29'h0, r[0], r[1], r[2]}, "display bits");
      end
      $display("test modes done");
      // shifted, decrementing state, then clear
      cmd(ains, 8'h05);
      cmd(adat, 8'h5a);
      {inc, shen, ac, sh} = {1'b0, 1'b1, 7'h7f, 32'd39};
      check_model();
      reg_wr(ains, 32'h1);
      repeat (120) @(posedge aclk);
      reg_rd(ains, s);
      chk({31'h0, s[7]}, 32'h1, "clear still busy");
      wait_idle();
      {inc, ac, sh} = {1'b1, 7'h0, 32'd0};
      foreach (mem[k]) mem[k] = `LCDX_SPACE_CODE;
      check_model();
      $display("test clear done");
      // random display ram traffic
      for (int i = 0; i < 40; i++)
      begin
         r = $urandom;
         if (r[3:0] == 4'h0)
         begin
            cmd(ains, {6'h1, r[5:4]});
            {inc, shen} = r[5:4];
         end
         else if (r[8])
         begin
            cmd(adat, r[31:24]);
            mem[ac] = r[31:24];
            sh = shen ? shift_nxt(sh, inc) : sh;
            ac = step(ac, inc, 1'b0);
         end
         else
         begin
            reg_rd(adat, s);
            chk(s, {24'h0, mem[ac]}, "ram read");
            post();
            ac = step(ac, inc, 1'b0);
         end
         check_model();
      end
      $display("test display ram done");
      // glyph ram from the top address: six-bit wrap, no shift
      cmd(ains, 8'h7f);
      {ac, gsel} = {7'h3f, 1'b1};
      for (int i = 0; i < 6; i++)
      begin
         r = $urandom;
         inc = (i == 0) ? 1'b1 : r[0];
         cmd(ains, {6'h1, inc, 1'b1});
         shen = 1'b1;
         if (r[8])
            reg_wr(adat, {24'h0, r[31:24]});
         else
            reg_rd(adat, s);
         post();
         ac = step(ac, inc, 1'b1);
         check_model();
      end
      $display("test glyph ram done");
      // return home after a shifting write
      cmd(ains, 8'h80);
      cmd(ains, 8'h07);
      cmd(adat, 8'ha5);
      r = $urandom;
      cmd(ains, {3'h1, r[4:0]});
      cmd(ains, {7'h1, r[0]});
      {ac, gsel, inc, shen, sh} = {7'h0, 3'b011, 32'd0};
      check_model();
      reg_rd(adat, s);
      chk(s, 32'ha5, "ram kept");
      post();
      $display("test home done");
      // tall font glyph mapping, last code outside the user range
      reg_wr(`LCDX_OFF_CFG, 32'h1);
      for (int i = 0; i < 8; i++)
      begin
         r = $urandom;
         r[7:4] = (i == 7) ? 4'h3 : 4'h0;
         reg_wr(`LCDX_OFF_GLYPH, {20'h0, r[11:0]});
         repeat (2) @(posedge aclk);
         reg_rd(`LCDX_OFF_GLYPH, s);
         if (i < 7)
            chk({25'h0, s[6:0]}, {25'h0, 1'b1, r[2:1], r[11:8]}, "glyph map");
         else
            chk({31'h0, s[6]}, 32'h0, "glyph miss");
      end
      $display("test glyph map done");
      finish_test();
   end
endmodule
`default_nettype wire
